// ==== pkg/lmou_map.svh ====
// Function
// (RULE1) a consumer of a loaded register issues only after that load completes
// (RULE2) waiting on every register source makes ordering chain through registers transitively
// (RULE3) compares wait for loaded sources, so predicated loads follow the producing load
// (RULE4) branches on a load-derived predicate order later loads after that load
// (RULE5) loads without a dependency chain may be outstanding and complete in any order
// (RULE6) an outstanding acquire load holds back every later operation
// (RULE7) a release store waits until all earlier loads and stores are visible
// (RULE8) buffered store data may be forwarded to local plain or acquire loads
// (RULE9) forwarding is suppressed from stores that sit in front of a fence
// (RULE10) same-address read/write hazards through memory resolve in program order
// (RULE11) a fence orders all earlier loads and stores before any later one
// (RULE12) a store is locally visible from the buffer before reaching the fabric
// (RULE13) each store drains only after the previous one is globally acknowledged
`ifndef LMOU_MAP_SVH
`define LMOU_MAP_SVH

`define LMOU_BIT_CLR    1'b0
`define LMOU_BIT_SET    1'b1
`define LMOU_CNT_STEP   1
`define LMOU_MIN_REGS   2
`define LMOU_MIN_DEPTH  2

`endif

// ==== pkg/lmou_pkg.sv ====
package lmou_pkg;

  typedef enum logic [2:0] {
    unordered_load,
    acquire_load,
    unordered_store,
    release_store,
    memory_fence_op,
    equality_compare_op,
    branch_op
  } lmou_op_t;

  typedef enum logic [1:0] {
    lmou_drain_idle,
    lmou_drain_send,
    lmou_drain_wait
  } lmou_drain_t;

endpackage

// ==== pkg/lmou_sb_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface lmou_sb_if #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 64
);
  logic              push;
  logic [ADDR_W-1:0] push_addr;
  logic [DATA_W-1:0] push_data;
  logic              push_rel;
  logic              mark_barrier;
  logic [ADDR_W-1:0] look_addr;
  logic              hit;
  logic              hit_blocked;
  logic [DATA_W-1:0] hit_data;
  logic              full;
  logic              empty;
  logic              barrier_any;
  logic [ADDR_W-1:0] head_addr;
  logic              drain_hold;

  modport ctrl (
    output push, push_addr, push_data, push_rel, mark_barrier, look_addr, drain_hold,
    input  hit, hit_blocked, hit_data, full, empty, barrier_any, head_addr
  );
  modport sbuf (
    input  push, push_addr, push_data, push_rel, mark_barrier, look_addr, drain_hold,
    output hit, hit_blocked, hit_data, full, empty, barrier_any, head_addr
  );
endinterface
`default_nettype wire

// ==== src/lmou_store_buf.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lmou_map.svh"
module lmou_store_buf #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 64,
  parameter int DEPTH  = 8
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  lmou_sb_if.sbuf                sb,
  output logic                   st_req_valid,
  input  wire logic              st_req_ready,
  output logic [ADDR_W-1:0]      st_req_addr,
  output logic [DATA_W-1:0]      st_req_data,
  output logic                   st_req_release,
  input  wire logic              st_ack
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < `LMOU_MIN_DEPTH || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("store buffer depth must be a power of two of at least two");
    end
  endgenerate

  logic [ADDR_W-1:0] ent_addr [DEPTH];
  logic [DATA_W-1:0] ent_data [DEPTH];
  logic [DEPTH-1:0]  ent_valid;
  logic [DEPTH-1:0]  ent_rel;
  logic [DEPTH-1:0]  ent_bar;
  logic [DEPTH-1:0]  ent_match;
  logic [PW-1:0]     head;
  logic [PW-1:0]     tail;
  logic [PW:0]       count;
  logic              pop;
  lmou_pkg::lmou_drain_t drain;

  assign pop            = (drain == lmou_pkg::lmou_drain_wait) && st_ack;
  assign sb.full        = (count == (PW+1)'(DEPTH));
  assign sb.empty       = (count == '0);
  assign sb.barrier_any = |(ent_bar & ent_valid);
  assign sb.head_addr   = ent_addr[head];

  // ****************************************************************
  // forwarding lookup
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_match
      assign ent_match[gi] = ent_valid[gi] && (ent_addr[gi] == sb.look_addr);
    end
  endgenerate

  // youngest matching entry wins, scanned in age order from the head
  always_comb begin
    logic [PW-1:0] idx;
    idx            = head;
    sb.hit         = `LMOU_BIT_CLR;
    sb.hit_blocked = `LMOU_BIT_CLR;
    sb.hit_data    = '0;
    for (int i = 0; i < DEPTH; i++) begin
      idx = head + PW'(i);
      if (ent_match[idx]) begin
        sb.hit         = `LMOU_BIT_SET;                      // [RULE8] [RULE12]
        sb.hit_blocked = ent_bar[idx];                       // [RULE9]
        sb.hit_data    = ent_data[idx];
      end
    end
  end

  // ****************************************************************
  // entry storage
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ent_valid <= '0;
      ent_bar   <= '0;
      ent_rel   <= '0;
    end else begin
      if (sb.mark_barrier) begin
        ent_bar <= ent_bar | ent_valid;                     // [RULE11]
      end
      if (pop) begin
        ent_valid[head] <= `LMOU_BIT_CLR;
        ent_bar[head]   <= `LMOU_BIT_CLR;
      end
      if (sb.push) begin
        ent_valid[tail] <= `LMOU_BIT_SET;
        ent_bar[tail]   <= `LMOU_BIT_CLR;
        ent_rel[tail]   <= sb.push_rel;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sb.push) begin
      ent_addr[tail] <= sb.push_addr;
      ent_data[tail] <= sb.push_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
    end else begin
      if (sb.push) begin
        tail <= tail + PW'(`LMOU_CNT_STEP);
      end
      if (pop) begin
        head <= head + PW'(`LMOU_CNT_STEP);
      end
      count <= count + (PW+1)'(sb.push) - (PW+1)'(pop);
    end
  end

  // ****************************************************************
  // drain to fabric, one store in flight at a time
  // ****************************************************************
  // one store in flight keeps global order equal to program order
  always_ff @(posedge core_clk) begin
    if (reset) begin
      drain          <= lmou_pkg::lmou_drain_idle;
      st_req_valid   <= `LMOU_BIT_CLR;
      st_req_addr    <= '0;
      st_req_data    <= '0;
      st_req_release <= `LMOU_BIT_CLR;
    end else begin
      unique case (drain)
        lmou_pkg::lmou_drain_idle: begin
          if (ent_valid[head] && !sb.drain_hold) begin     // [RULE10]
            drain          <= lmou_pkg::lmou_drain_send;
            st_req_valid   <= `LMOU_BIT_SET;
            st_req_addr    <= ent_addr[head];
            st_req_data    <= ent_data[head];
            st_req_release <= ent_rel[head];
          end
        end
        lmou_pkg::lmou_drain_send: begin
          if (st_req_ready) begin
            drain        <= lmou_pkg::lmou_drain_wait;
            st_req_valid <= `LMOU_BIT_CLR;
          end
        end
        lmou_pkg::lmou_drain_wait: begin
          if (st_ack) begin
            drain <= lmou_pkg::lmou_drain_idle;             // [RULE13]
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== src/lmou_order_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lmou_map.svh"
module lmou_order_unit #(
  parameter int ADDR_W   = 32,
  parameter int DATA_W   = 64,
  parameter int NREGS    = 32,
  parameter int SB_DEPTH = 8,
  localparam int RW      = $clog2(NREGS)
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              op_valid,
  output logic                   op_ready,
  input  wire lmou_pkg::lmou_op_t op_kind,
  input  wire logic [RW-1:0]     op_dst,
  input  wire logic [RW-1:0]     op_src_a,
  input  wire logic [RW-1:0]     op_src_b,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [DATA_W-1:0] op_data,
  output logic                   wb_valid,
  output logic [RW-1:0]          wb_reg,
  output logic [DATA_W-1:0]      wb_data,
  output logic                   ld_req_valid,
  input  wire logic              ld_req_ready,
  output logic [ADDR_W-1:0]      ld_req_addr,
  output logic [RW-1:0]          ld_req_tag,
  input  wire logic              ld_rsp_valid,
  input  wire logic [RW-1:0]     ld_rsp_tag,
  input  wire logic [DATA_W-1:0] ld_rsp_data,
  output logic                   st_req_valid,
  input  wire logic              st_req_ready,
  output logic [ADDR_W-1:0]      st_req_addr,
  output logic [DATA_W-1:0]      st_req_data,
  output logic                   st_req_release,
  input  wire logic              st_ack
);
  generate
    if (NREGS < `LMOU_MIN_REGS || (NREGS & (NREGS - 1)) != 0) begin : g_bad_regs
      $error("register count must be a power of two of at least two");
    end
  endgenerate

  lmou_sb_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) sb ();

  lmou_store_buf #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .DEPTH  (SB_DEPTH)
  ) u_store_buf (
    .core_clk       (core_clk),
    .reset          (reset),
    .sb             (sb.sbuf),
    .st_req_valid   (st_req_valid),
    .st_req_ready   (st_req_ready),
    .st_req_addr    (st_req_addr),
    .st_req_data    (st_req_data),
    .st_req_release (st_req_release),
    .st_ack         (st_ack)
  );

  logic [NREGS-1:0]  busy;
  logic [ADDR_W-1:0] busy_addr [NREGS];
  logic [NREGS-1:0]  war_match;
  logic [RW:0]       loads_out;
  logic              acq_busy;
  logic [RW-1:0]     acq_tag;
  logic              is_load;
  logic              is_store;
  logic              src_busy;
  logic              slot_free;
  logic              forward;
  logic              ok;
  logic              accept;
  logic              to_fabric;
  logic              rsp_done;

  // ****************************************************************
  // issue decision
  // ****************************************************************
  assign is_load   = (op_kind == lmou_pkg::unordered_load) || (op_kind == lmou_pkg::acquire_load);
  assign is_store  = (op_kind == lmou_pkg::unordered_store) || (op_kind == lmou_pkg::release_store);
  assign src_busy  = busy[op_src_a] || busy[op_src_b];                     // [RULE1] [RULE2]
  assign slot_free = !ld_req_valid || ld_req_ready;
  assign sb.look_addr = op_addr;
  assign forward   = sb.hit && !sb.hit_blocked;                           // [RULE8] [RULE9]

  // forwarding shares the writeback port with fabric responses and yields to them
  always_comb begin
    ok = `LMOU_BIT_CLR;
    unique case (op_kind)
      lmou_pkg::unordered_load,
      lmou_pkg::acquire_load: begin
        // [RULE5] independent loads go out without waiting on each other
        ok = !busy[op_dst] && !sb.barrier_any                              // [RULE11]
             && (sb.hit ? (forward && !ld_rsp_valid) : slot_free);         // [RULE10]
      end
      lmou_pkg::unordered_store: begin
        ok = !sb.full;
      end
      lmou_pkg::release_store: begin
        ok = !sb.full && (loads_out == '0);                               // [RULE7]
      end
      lmou_pkg::memory_fence_op: begin
        ok = (loads_out == '0);                                           // [RULE11]
      end
      lmou_pkg::equality_compare_op: begin
        ok = `LMOU_BIT_SET;                                               // [RULE3]
      end
      lmou_pkg::branch_op: begin
        ok = `LMOU_BIT_SET;                                               // [RULE4]
      end
      default: begin
        ok = `LMOU_BIT_CLR;
      end
    endcase
  end

  // compares only resolve once their loaded sources are back, so no predicate
  // or branch outcome can ever run ahead of the load that fed it
  assign op_ready  = ok && !src_busy && !acq_busy;                         // [RULE6] [RULE3] [RULE4]
  assign accept    = op_valid && op_ready;
  assign to_fabric = accept && is_load && !sb.hit;
  assign rsp_done  = ld_rsp_valid && busy[ld_rsp_tag];

  assign sb.push         = accept && is_store;                            // [RULE12]
  assign sb.push_addr    = op_addr;
  assign sb.push_data    = op_data;
  assign sb.push_rel     = (op_kind == lmou_pkg::release_store);
  assign sb.mark_barrier = accept && (op_kind == lmou_pkg::memory_fence_op);

  // ****************************************************************
  // same-address hazard against loads still in flight
  // ****************************************************************
  genvar gr;
  generate
    for (gr = 0; gr < NREGS; gr++) begin : g_war
      assign war_match[gr] = busy[gr] && (busy_addr[gr] == sb.head_addr);
    end
  endgenerate
  // a store may not overtake an older load of the same address
  assign sb.drain_hold = |war_match;                                      // [RULE10]

  // ****************************************************************
  // register scoreboard
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy <= '0;
    end else begin
      if (rsp_done) begin
        busy[ld_rsp_tag] <= `LMOU_BIT_CLR;
      end
      if (to_fabric) begin
        busy[op_dst] <= `LMOU_BIT_SET;                                    // [RULE1]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (to_fabric) begin
      busy_addr[op_dst] <= op_addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      loads_out <= '0;
    end else begin
      loads_out <= loads_out + (RW+1)'(to_fabric) - (RW+1)'(rsp_done);
    end
  end

  // ****************************************************************
  // acquire tracking
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      acq_busy <= `LMOU_BIT_CLR;
      acq_tag  <= '0;
    end else if (to_fabric && op_kind == lmou_pkg::acquire_load) begin
      acq_busy <= `LMOU_BIT_SET;                                          // [RULE6]
      acq_tag  <= op_dst;
    end else if (rsp_done && ld_rsp_tag == acq_tag) begin
      acq_busy <= `LMOU_BIT_CLR;
    end
  end

  // ****************************************************************
  // load request slot
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ld_req_valid <= `LMOU_BIT_CLR;
      ld_req_addr  <= '0;
      ld_req_tag   <= '0;
    end else if (to_fabric) begin
      ld_req_valid <= `LMOU_BIT_SET;
      ld_req_addr  <= op_addr;
      ld_req_tag   <= op_dst;
    end else if (ld_req_ready) begin
      ld_req_valid <= `LMOU_BIT_CLR;
    end
  end

  // ****************************************************************
  // writeback
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_valid <= `LMOU_BIT_CLR;
      wb_reg   <= '0;
      wb_data  <= '0;
    end else if (rsp_done) begin
      wb_valid <= `LMOU_BIT_SET;
      wb_reg   <= ld_rsp_tag;
      wb_data  <= ld_rsp_data;
    end else if (accept && is_load && forward) begin
      wb_valid <= `LMOU_BIT_SET;                                          // [RULE8]
      wb_reg   <= op_dst;
      wb_data  <= sb.hit_data;
    end else begin
      wb_valid <= `LMOU_BIT_CLR;
    end
  end
endmodule
`default_nettype wire

// ==== tb/lmou_order_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module lmou_order_properties #(
  parameter int  NREGS  = 32,
  parameter int  ADDR_W = 32,
  localparam int RW     = $clog2(NREGS)
) (
  input wire logic               core_clk,
  input wire logic               reset,
  input wire logic               op_valid,
  input wire logic               op_ready,
  input wire lmou_pkg::lmou_op_t op_kind,
  input wire logic [RW-1:0]      op_dst,
  input wire logic [RW-1:0]      op_src_a,
  input wire logic [RW-1:0]      op_src_b,
  input wire logic               wb_valid,
  input wire logic [RW-1:0]      wb_reg,
  input wire logic               ld_req_valid,
  input wire logic               ld_req_ready,
  input wire logic [ADDR_W-1:0]  ld_req_addr,
  input wire logic               st_req_valid,
  input wire logic               st_req_ready,
  input wire logic               st_ack
);
  // ********
  // outstanding loads and stores
  // ********
  logic [NREGS-1:0] pend;
  logic [NREGS-1:0] wbm;
  logic [NREGS-1:0] live;
  logic [RW-1:0]    acq_reg;
  logic             acq_pend;
  logic             acq_live;
  logic             st_fly;
  logic             ld_take;
  // a load retiring this cycle no longer holds back its consumers
  assign wbm = wb_valid ? NREGS'(1) << wb_reg : '0;
  assign live = pend & ~wbm;
  assign acq_live = acq_pend && !(wb_valid && wb_reg == acq_reg);
  assign ld_take = op_valid && op_ready
    && (op_kind == lmou_pkg::unordered_load || op_kind == lmou_pkg::acquire_load);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend <= '0;
    end else begin
      pend <= live | (ld_take ? NREGS'(1) << op_dst : '0);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      acq_pend <= 1'h0;
      acq_reg  <= '0;
    end else if (ld_take && op_kind == lmou_pkg::acquire_load) begin
      acq_pend <= 1'h1;
      acq_reg  <= op_dst;
    end else if (acq_pend && !acq_live) begin
      acq_pend <= 1'h0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_fly <= 1'h0;
    end else if (st_req_valid && st_req_ready) begin
      st_fly <= 1'h1;
    end else if (st_ack) begin
      st_fly <= 1'h0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_src_stall: assert property (
    op_valid && (live[op_src_a] || live[op_src_b]) |-> !op_ready)
    else $error("op taken while a source load is outstanding");
  a_acq_holds: assert property (
    op_valid && acq_live |-> !op_ready)
    else $error("op taken past an outstanding acquire load");
  a_rel_waits: assert property (
    op_valid && op_kind == lmou_pkg::release_store && live != '0 |-> !op_ready)
    else $error("release store taken with loads outstanding");
  a_fence_waits: assert property (
    op_valid && op_kind == lmou_pkg::memory_fence_op && live != '0 |-> !op_ready)
    else $error("fence taken with loads outstanding");
  a_one_store: assert property (
    st_fly |-> !st_req_valid)
    else $error("store offered before previous acknowledge");
  a_ld_hold: assert property (
    ld_req_valid && !ld_req_ready |=> ld_req_valid && $stable(ld_req_addr))
    else $error("load request dropped or changed while waiting");
  a_wb_owner: assert property (
    wb_valid |-> pend[wb_reg])
    else $error("writeback for a register with no load");
  a_reset_quiet: assert property (disable iff (1'h0)
    reset |=> !wb_valid && !ld_req_valid && !st_req_valid)
    else $error("output active after reset");
endmodule
bind lmou_order_unit lmou_order_properties #(.NREGS(NREGS), .ADDR_W(ADDR_W)) i_props (
  .core_clk, .reset, .op_valid, .op_ready, .op_kind, .op_dst, .op_src_a, .op_src_b,
  .wb_valid, .wb_reg, .ld_req_valid, .ld_req_ready, .ld_req_addr,
  .st_req_valid, .st_req_ready, .st_ack
);
`default_nettype wire

// ==== tb/lmou_fabric_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lmou_fabric_model #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 64,
  parameter int RW     = 5
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              ld_req_valid,
  output logic                   ld_req_ready,
  input  wire logic [ADDR_W-1:0] ld_req_addr,
  input  wire logic [RW-1:0]     ld_req_tag,
  output logic                   ld_rsp_valid,
  output logic [RW-1:0]          ld_rsp_tag,
  output logic [DATA_W-1:0]      ld_rsp_data,
  input  wire logic              st_req_valid,
  output logic                   st_req_ready,
  input  wire logic [ADDR_W-1:0] st_req_addr,
  input  wire logic [DATA_W-1:0] st_req_data,
  output logic                   st_ack
);
  // ********
  // memory, out-of-order load replies, one store in flight
  // ********
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] q_addr [$];
  logic [RW-1:0]     q_tag [$];
  int                seed = 70;
  int                st_wait;
  int                k;
  initial begin
    ld_req_ready = 1'h0;
    ld_rsp_valid = 1'h0;
    ld_rsp_tag = '0;
    ld_rsp_data = '0;
    st_req_ready = 1'h0;
    st_ack = 1'h0;
    st_wait = 0;
  end
  always @(posedge core_clk) begin
    ld_req_ready <= 1'($random(seed));
    st_req_ready <= 1'($random(seed));
    ld_rsp_valid <= 1'h0;
    // idle reply lines toggle so stale data cannot pass for a reply
    ld_rsp_tag <= ~ld_rsp_tag;
    ld_rsp_data <= ~ld_rsp_data;
    st_ack <= 1'h0;
    if (reset) begin
      q_addr.delete();
      q_tag.delete();
      st_wait = 0;
    end else begin
      if (ld_req_valid && ld_req_ready) begin
        q_addr.push_back(ld_req_addr);
        q_tag.push_back(ld_req_tag);
      end
      if (q_tag.size() > 0 && {$random(seed)} % 3 == 0) begin
        k = {$random(seed)} % q_tag.size();
        ld_rsp_valid <= 1'h1;
        ld_rsp_tag <= q_tag[k];
        ld_rsp_data <= mem.exists(q_addr[k]) ? mem[q_addr[k]]
                                             : DATA_W'({q_addr[k], ~q_addr[k]});
        q_addr.delete(k);
        q_tag.delete(k);
      end
      if (st_req_valid && st_req_ready) begin
        mem[st_req_addr] = st_req_data;
        st_wait = 1 + {$random(seed)} % 6;
      end else if (st_wait > 0) begin
        st_wait--;
        if (st_wait == 0) st_ack <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/local_memory_ordering_unit_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module local_memory_ordering_unit_test;
  localparam int NR = 8;
  logic               core_clk;
  logic               reset;
  logic               op_valid;
  logic               op_ready;
  lmou_pkg::lmou_op_t op_kind;
  logic [2:0]         op_dst;
  logic [2:0]         op_src_a;
  logic [2:0]         op_src_b;
  logic [31:0]        op_addr;
  logic [63:0]        op_data;
  logic               wb_valid;
  logic [2:0]         wb_reg;
  logic [63:0]        wb_data;
  logic               lq_v, lq_r, lr_v, sq_v, sq_r, sq_rel, st_ack;
  logic [31:0]        lq_a, sq_a;
  logic [2:0]         lq_t, lr_t;
  logic [63:0]        lr_d, sq_d;
  logic [63:0]        exp_val [NR];
  logic [63:0]        shadow [logic [31:0]];
  logic [NR-1:0]      pnd = '0;
  int                 ack_wb [NR];
  int                 seed = 70;
  int                 error_cnt = 0;
  int                 compares = 0;
  int                 n_st = 0;
  int                 n_ack = 0;
  int                 tgt;
  int                 n;
  logic [64:0]        st_q [$];
  logic [64:0]        st_exp;
  lmou_order_unit #(.NREGS(NR), .SB_DEPTH(4)) i_dut (
    .core_clk, .reset, .op_valid, .op_ready, .op_kind, .op_dst, .op_src_a, .op_src_b,
    .op_addr, .op_data, .wb_valid, .wb_reg, .wb_data,
    .ld_req_valid(lq_v), .ld_req_ready(lq_r), .ld_req_addr(lq_a), .ld_req_tag(lq_t),
    .ld_rsp_valid(lr_v), .ld_rsp_tag(lr_t), .ld_rsp_data(lr_d),
    .st_req_valid(sq_v), .st_req_ready(sq_r), .st_req_addr(sq_a), .st_req_data(sq_d),
    .st_req_release(sq_rel), .st_ack
  );
  lmou_fabric_model #(.RW(3)) i_fab (
    .core_clk, .reset, .ld_req_valid(lq_v), .ld_req_ready(lq_r), .ld_req_addr(lq_a),
    .ld_req_tag(lq_t), .ld_rsp_valid(lr_v), .ld_rsp_tag(lr_t), .ld_rsp_data(lr_d),
    .st_req_valid(sq_v), .st_req_ready(sq_r), .st_req_addr(sq_a), .st_req_data(sq_d),
    .st_ack
  );
  always #2.5 core_clk = ~core_clk;
  // ********
  // checking and stimulus
  // ********
  task automatic results();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  function automatic logic [63:0] mem_val(input logic [31:0] a);
    return shadow.exists(a) ? shadow[a] : {a, ~a};
  endfunction
  // op_valid stays up after a take so back-to-back ops need no gap; drain drops it
  task automatic send(input lmou_pkg::lmou_op_t k, input logic [2:0] d, s,
                      input logic [31:0] a, input logic [63:0] v);
    int i;
    op_valid <= 1'h1;
    op_kind <= k;
    op_dst <= d;
    op_src_a <= s;
    op_src_b <= d;
    op_addr <= a;
    op_data <= v;
    for (i = 0; i < 400; i++) begin
      @(posedge core_clk);
      if (op_ready === 1'h1) break;
    end
    if (i == 400) begin
      error_cnt++;
      results();
    end
    if (k == lmou_pkg::unordered_load || k == lmou_pkg::acquire_load) begin
      exp_val[d] = mem_val(a);
      pnd[d] = 1'h1;
    end
    if (k == lmou_pkg::unordered_store || k == lmou_pkg::release_store) begin
      shadow[a] = v;
      st_q.push_back({k == lmou_pkg::release_store, v});
      n_st++;
    end
  endtask
  task automatic drain();
    int i;
    op_valid <= 1'h0;
    for (i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if (pnd == '0 && n_ack == n_st) break;
    end
    if (i == 3000) begin
      error_cnt++;
      results();
    end
    @(posedge core_clk);
  endtask
  always @(negedge core_clk) begin
    if (wb_valid === 1'h1) begin
      check(wb_data, exp_val[wb_reg]);
      check(pnd[wb_reg], 1'h1);
      pnd[wb_reg] = 1'h0;
      ack_wb[wb_reg] = n_ack;
    end
    // stores leave one at a time in program order, so the queue head is due
    if (sq_v === 1'h1 && sq_r === 1'h1) begin
      st_exp = st_q.pop_front();
      check(sq_d, st_exp[63:0]);
      check(sq_rel, st_exp[64]);
    end
    if (st_ack === 1'h1) n_ack++;
  end
  initial begin
    core_clk = 1'h0;
    reset = 1'h1;
    op_valid = 1'h0;
    op_kind = lmou_pkg::unordered_load;
    {op_dst, op_src_a, op_src_b, op_addr, op_data} = '0;
    repeat (6) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    send(lmou_pkg::unordered_store, 7, 7, 32'h10, 64'hA5A5_0000_1234_5678);
    send(lmou_pkg::unordered_load, 1, 1, 32'h10, 64'h0);
    op_valid <= 1'h0;
    @(negedge core_clk);
    check(wb_valid, 1'h1);
    @(posedge core_clk);
    send(lmou_pkg::unordered_store, 7, 7, 32'h20, 64'h1);
    tgt = n_st;
    send(lmou_pkg::memory_fence_op, 7, 7, 32'h0, 64'h0);
    send(lmou_pkg::acquire_load, 2, 2, 32'h20, 64'h0);
    send(lmou_pkg::unordered_load, 3, 3, 32'h28, 64'h0);
    send(lmou_pkg::unordered_load, 4, 4, 32'h30, 64'h0);
    send(lmou_pkg::equality_compare_op, 4, 4, 32'h0, 64'h0);
    send(lmou_pkg::branch_op, 4, 4, 32'h0, 64'h0);
    send(lmou_pkg::unordered_load, 5, 4, 32'h38, 64'h0);
    send(lmou_pkg::unordered_store, 7, 7, 32'h30, 64'h77);
    send(lmou_pkg::release_store, 7, 7, 32'h08, 64'h99);
    send(lmou_pkg::unordered_load, 6, 6, 32'h30, 64'h0);
    // six stores back to back fill the four-entry buffer and stall the pipeline
    for (n = 0; n < 6; n++) send(lmou_pkg::unordered_store, 7, 7, 32'(n * 8), 64'(n));
    drain();
    check(ack_wb[2] >= tgt, 1'h1);
    for (n = 0; n < 400; n++) begin
      send(lmou_pkg::lmou_op_t'(3'({$random(seed)} % 7)), 3'($random(seed)),
           3'($random(seed)), 32'({$random(seed)} % 4) << 3, {$random(seed), $random(seed)});
    end
    drain();
    results();
  end
endmodule
`default_nettype wire
